/* common/wfs_pkg.sv */
// constants, register map and lamp lookup for the welder fault supervisor
// assumes a 100 MHz pclk and a 1 ms tick made by the top module
package wfs_pkg;

	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 10;
	localparam int TICK_PERIOD_NS = 1_000_000;
	localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
	localparam int OVC_LIMIT_S = 2;
	localparam int GAS_LIMIT_MIN = 2;
	localparam int OVC_LIMIT_MS = OVC_LIMIT_S * 1000;
	localparam int GAS_LIMIT_MS = GAS_LIMIT_MIN * 60 * 1000;
	localparam int STARTUP_MS = 20;
	localparam int TMR_W = 17;
	localparam logic [10:0] BLINK_PERIOD_MS = 11'h03E8;
	localparam logic [10:0] FLASH_HALF_MS = 11'h00FA;
	localparam logic [10:0] DFL_ON_MS = 11'h0096;

	// ****************************************
	// error numbers and fault bit positions
	// ****************************************
	localparam logic [3:0] ERR_NONE = 4'h0;
	localparam logic [3:0] ERR_CURDET = 4'hB;
	localparam int NFLT = 9;
	localparam int F_FREQ = 0;
	localparam int F_TEMP = 1;
	localparam int F_OVERV = 2;
	localparam int F_UNDERV = 3;
	localparam int F_MODE = 4;
	localparam int F_TORCH = 5;
	localparam int F_GAS = 6;
	localparam int F_OVC = 7;
	localparam int F_CPU = 8;

	// ****************************************
	// register map (byte addresses)
	// ****************************************
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_MASK = 8'h08;
	localparam logic [7:0] REG_ERR = 8'h0C;
	localparam logic [7:0] REG_LIVE = 8'h10;
	localparam logic [7:0] REG_MODEOK = 8'h14;
	localparam int CTRL_WELD_REQ = 0;
	localparam logic [15:0] MODEOK_RST = 16'h00FF;
	localparam logic [NFLT-1:0] MASK_RST = 9'h000;

	typedef enum logic [1:0] {WFS_LAMP_OFF, WFS_LAMP_STEADY, WFS_LAMP_FLASH, WFS_LAMP_DFLASH}
		wfs_lamp_t;

	// panel style, red, green for each error number
	function automatic logic [3:0] wfs_lamp_lut(input logic [3:0] code);
		logic [3:0] r;
		r = {WFS_LAMP_OFF, 2'b00};
		unique case (code)
			4'h1: r = {WFS_LAMP_STEADY, 2'b11};
			4'h2: r = {WFS_LAMP_FLASH, 2'b10};
			4'h3: r = {WFS_LAMP_STEADY, 2'b01};
			4'h4: r = {WFS_LAMP_STEADY, 2'b00};
			4'h5: r = {WFS_LAMP_FLASH, 2'b11};
			4'h6: r = {WFS_LAMP_FLASH, 2'b00};
			4'h7: r = {WFS_LAMP_FLASH, 2'b01};
			4'h8: r = {WFS_LAMP_STEADY, 2'b01};
			4'h9: r = {WFS_LAMP_DFLASH, 2'b10};
			4'hA: r = {WFS_LAMP_DFLASH, 2'b01};
			4'hB: r = {WFS_LAMP_DFLASH, 2'b00};
			default: r = {WFS_LAMP_OFF, 2'b00};
		endcase
		return r;
	endfunction

endpackage

/* common/wfs_lamp_if.sv */
// carrier between the supervisor and its blink pattern generator
// assumes both ends on pclk
`timescale 1ns/1ps
interface wfs_lamp_if;
	logic tick;
	logic flash;
	logic dflash;
	logic dflash_end;
	modport gen
	(
		input tick,
		output flash,
		output dflash,
		output dflash_end
	);
	modport use_side
	(
		output tick,
		input flash,
		input dflash,
		input dflash_end
	);
endinterface

/* logic/wfs_blink.sv */
// blink pattern generator: single flash and double flash waveforms
// assumes a one-cycle 1 ms tick on the interface
`timescale 1ns/1ps
module wfs_blink
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// patterns
	wfs_lamp_if.gen lamp
);
	import wfs_pkg::*;

	logic [10:0] ms_reg;
	logic [10:0] ms_next;
	wire wrap = (ms_reg == BLINK_PERIOD_MS - 11'h0001);

	assign ms_next = wrap ? 11'h0000 : ms_reg + 11'h0001;
	assign lamp.flash = (ms_reg < FLASH_HALF_MS)
		|| ((ms_reg >= 2 * FLASH_HALF_MS) && (ms_reg < 3 * FLASH_HALF_MS));
	assign lamp.dflash = (ms_reg < DFL_ON_MS)
		|| ((ms_reg >= 2 * DFL_ON_MS) && (ms_reg < 3 * DFL_ON_MS));
	assign lamp.dflash_end = lamp.tick && wrap;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ms_reg <= 11'h0000;
		else if (lamp.tick)
			ms_reg <= ms_next;
	end
endmodule

/* logic/wfs_persist.sv */
// persistence timer: reports a condition held for at least limit ticks
// assumes cond is already synchronised to pclk
`timescale 1ns/1ps
module wfs_persist
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// timing
	input wire logic tick,
	input wire logic [wfs_pkg::TMR_W-1:0] limit,
	// condition
	input wire logic cond,
	output logic over
);
	import wfs_pkg::*;

	logic [TMR_W-1:0] cnt_reg;
	wire at_limit = (cnt_reg >= limit);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cnt_reg <= '0;
		else if (!cond)
			cnt_reg <= '0;
		else if (tick && !at_limit)
			cnt_reg <= cnt_reg + 1'b1;
	end

	assign over = cond && at_limit;
endmodule

/* logic/wfs_supervisor.sv */
// welder fault supervisor: fault latching, error number, lamps, weld stop, apb registers
// assumes condition pins are asynchronous, presetn is the control power-on reset
// What this block does
// - Any active fault stops the weld output and drives the warning lamp steady or flashing.
// - An unstable supply frequency seen at power-up latches a fault that only reset clears.
// - Duty-cycle overrun or over-temperature flashes the lamp and stops output until it recovers.
// - Input overvoltage lights the lamp steadily, stops output and latches until reset.
// - Input undervoltage lights the lamp, stops output and latches until reset.
// - An unsupported process mode flashes the lamp and stops output until a valid mode returns.
// - A torch trigger held at power-up gives single flash and blocks output until released.
// - Gas-check held over two minutes gives single flash and stops until set back to weld.
// - Overcurrent or short held over two seconds lights the lamp and latches until reset.
// - A processor fault double-flashes the lamp and stops the weld output at the end of the current blink period.
//
// Local design decisions: the address map and the APB slave port.
`timescale 1ns/1ps
module wfs_supervisor
#(
	parameter int TICK_CYC = wfs_pkg::TICK_CYCLES,
	parameter int OVC_MS = wfs_pkg::OVC_LIMIT_MS,
	parameter int GAS_MS = wfs_pkg::GAS_LIMIT_MS
)
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// machine conditions
	input wire logic freq_unstable,
	input wire logic temp_over,
	input wire logic duty_over,
	input wire logic volt_high,
	input wire logic volt_low,
	input wire logic [3:0] process_mode_selector,
	input wire logic torch_trigger,
	input wire logic gas_check,
	input wire logic overcurrent,
	input wire logic cpu_fault,
	// outputs to the machine
	output logic weld_enable,
	output logic warning_lamp,
	output logic fault_lamp_red,
	output logic fault_lamp_green,
	output logic [3:0] error_code,
	output logic irq
);
	import wfs_pkg::*;

	// ****************************************
	// input synchronisers
	// ****************************************
	localparam int NIN = 13;
	logic [NIN-1:0] sync1_reg;
	logic [NIN-1:0] sync2_reg;
	wire [NIN-1:0] pins = {process_mode_selector, freq_unstable, temp_over, duty_over,
		volt_high, volt_low, torch_trigger, gas_check, overcurrent, cpu_fault};

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end
		else
		begin
			sync1_reg <= pins;
			sync2_reg <= sync1_reg;
		end
	end

	wire [3:0] mode_s = sync2_reg[12:9];
	wire freq_s = sync2_reg[8];
	wire temp_s = sync2_reg[7];
	wire duty_s = sync2_reg[6];
	wire vhi_s = sync2_reg[5];
	wire vlo_s = sync2_reg[4];
	wire torch_s = sync2_reg[3];
	wire gas_s = sync2_reg[2];
	wire ovc_s = sync2_reg[1];
	wire cpu_s = sync2_reg[0];

	// ****************************************
	// mode word filter
	// ****************************************
	// the selector is a 4-bit word: a new value is taken only once two samples agree,
	// so a word torn while the selector turns never reaches the mode check
	logic [3:0] mode_prev_reg;
	logic [3:0] mode_held_reg;
	wire mode_settled = (mode_s == mode_prev_reg);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mode_prev_reg <= 4'h0;
			mode_held_reg <= 4'h0;
		end
		else
		begin
			mode_prev_reg <= mode_s;
			if (mode_settled)
				mode_held_reg <= mode_s;
		end
	end

	// ****************************************
	// 1 ms tick and power-up window
	// ****************************************
	logic [TMR_W-1:0] div_reg;
	logic tick_reg;
	logic [TMR_W-1:0] pup_reg;
	wire div_wrap = (div_reg == TMR_W'(TICK_CYC - 1));
	wire in_pup = (pup_reg < TMR_W'(STARTUP_MS));

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			div_reg <= '0;
			tick_reg <= 1'b0;
			pup_reg <= '0;
		end
		else
		begin
			div_reg <= div_wrap ? '0 : div_reg + 1'b1;
			tick_reg <= div_wrap;
			if (tick_reg && in_pup)
				pup_reg <= pup_reg + 1'b1;
		end
	end

	// ****************************************
	// blink patterns and persistence timers
	// ****************************************
	wfs_lamp_if lamp_bus();
	assign lamp_bus.tick = tick_reg;

	wfs_blink u_blink
	(
		.pclk(pclk),
		.presetn(presetn),
		.lamp(lamp_bus)
	);

	wire ovc_over;
	wire gas_over;

	wfs_persist u_ovc_timer
	(
		.pclk(pclk),
		.presetn(presetn),
		.tick(tick_reg),
		.limit(TMR_W'(OVC_MS)),
		.cond(ovc_s),
		.over(ovc_over)
	);

	wfs_persist u_gas_timer
	(
		.pclk(pclk),
		.presetn(presetn),
		.tick(tick_reg),
		.limit(TMR_W'(GAS_MS)),
		.cond(gas_s),
		.over(gas_over)
	);

	// ****************************************
	// fault state
	// ****************************************
	logic [NFLT-1:0] fault_reg;
	logic [NFLT-1:0] fault_next;
	logic [15:0] modeok_reg;
	logic cpu_stop_reg;
	wire mode_bad = !modeok_reg[mode_held_reg];

	always_comb
	begin
		fault_next = fault_reg;
		fault_next[F_FREQ] = fault_reg[F_FREQ] || (in_pup && freq_s);
		fault_next[F_TEMP] = temp_s || duty_s;
		fault_next[F_OVERV] = fault_reg[F_OVERV] || vhi_s;
		fault_next[F_UNDERV] = fault_reg[F_UNDERV] || vlo_s;
		fault_next[F_MODE] = mode_bad;
		fault_next[F_TORCH] = torch_s && (fault_reg[F_TORCH] || in_pup);
		fault_next[F_GAS] = gas_over;
		fault_next[F_OVC] = fault_reg[F_OVC] || ovc_over;
		fault_next[F_CPU] = fault_reg[F_CPU] || cpu_s;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			fault_reg <= '0;
			cpu_stop_reg <= 1'b0;
		end
		else
		begin
			fault_reg <= fault_next;
			if (fault_reg[F_CPU] && lamp_bus.dflash_end)
				cpu_stop_reg <= 1'b1;
		end
	end

	// ****************************************
	// error number and lamps
	// ****************************************
	function automatic logic [3:0] lowest_code(input logic [NFLT-1:0] f);
		logic [3:0] c;
		c = ERR_NONE;
		for (int i = NFLT - 1; i >= 0; i--)
			if (f[i])
				c = 4'(i + 1);
		return c;
	endfunction

	wire [3:0] code_now = lowest_code(fault_reg);
	wire [3:0] lut = wfs_lamp_lut(code_now);
	wire [1:0] style = lut[3:2];
	wire panel_now = (style == WFS_LAMP_STEADY)
		|| ((style == WFS_LAMP_FLASH) && lamp_bus.flash)
		|| ((style == WFS_LAMP_DFLASH) && lamp_bus.dflash);
	wire any_stop = (|fault_reg[F_OVC:F_FREQ]) || cpu_stop_reg;

	logic [31:0] ctrl_reg;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			error_code <= ERR_NONE;
			warning_lamp <= 1'b0;
			fault_lamp_red <= 1'b0;
			fault_lamp_green <= 1'b0;
			weld_enable <= 1'b0;
		end
		else
		begin
			error_code <= code_now;
			warning_lamp <= panel_now;
			fault_lamp_red <= lut[1];
			fault_lamp_green <= lut[0];
			weld_enable <= ctrl_reg[CTRL_WELD_REQ] && !any_stop;
		end
	end

	// ****************************************
	// apb register file and interrupt
	// ****************************************
	logic [NFLT-1:0] status_reg;
	logic [NFLT-1:0] mask_reg;
	logic [NFLT-1:0] fault_d_reg;
	wire setup = psel && !penable;
	wire wr_go = psel && penable && pready && pwrite;
	wire hit_ctrl = (paddr == REG_CTRL);
	wire hit_stat = (paddr == REG_STATUS);
	wire hit_mask = (paddr == REG_MASK);
	wire hit_err = (paddr == REG_ERR);
	wire hit_live = (paddr == REG_LIVE);
	wire hit_mok = (paddr == REG_MODEOK);
	wire mapped = hit_ctrl || hit_stat || hit_mask || hit_err || hit_live || hit_mok;
	wire [NFLT-1:0] rise = fault_reg & ~fault_d_reg;
	wire [NFLT-1:0] w1c = (wr_go && hit_stat) ? pwdata[NFLT-1:0] : '0;
	wire [31:0] rd_mux = hit_ctrl ? ctrl_reg
		: hit_stat ? {23'h00_0000, status_reg}
		: hit_mask ? {23'h00_0000, mask_reg}
		: hit_err ? {28'h000_0000, error_code}
		: hit_live ? {23'h00_0000, fault_reg}
		: hit_mok ? {16'h0000, modeok_reg}
		: 32'h0000_0000;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_reg <= 32'h0000_0000;
			mask_reg <= MASK_RST;
			modeok_reg <= MODEOK_RST;
			status_reg <= '0;
			fault_d_reg <= '0;
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			irq <= 1'b0;
		end
		else
		begin
			fault_d_reg <= fault_reg;
			status_reg <= (status_reg & ~w1c) | rise;
			irq <= |(status_reg & mask_reg);
			pready <= setup;
			if (setup)
			begin
				prdata <= mapped ? rd_mux : 32'h0000_0000;
				pslverr <= !mapped;
			end
			if (wr_go && hit_ctrl)
				ctrl_reg <= {31'h0000_0000, pwdata[CTRL_WELD_REQ]};
			if (wr_go && hit_mask)
				mask_reg <= pwdata[NFLT-1:0];
			if (wr_go && hit_mok)
				modeok_reg <= pwdata[15:0];
		end
	end
endmodule

/* verif/wfs_machine_model.sv */
// machine side: condition pins and mode selector
// assumes the bench sets cv and mode after rising edges
`timescale 1ns/1ps
module wfs_machine_model
(
	// control
	input wire logic pclk,
	input wire logic [8:0] cv,
	input wire logic [3:0] mode,
	// pins
	output logic [8:0] pins,
	output logic [3:0] sel
);
	// conditions change only at clock edges, like a slow sensor
	always_ff @(posedge pclk)
	begin
		pins <= cv;
		sel <= mode;
	end
endmodule

/* verif/wfs_supervisor_sva.sv */
// port assertions for the welder fault supervisor
// assumes binding into wfs_supervisor
`timescale 1ns/1ps
module wfs_sva
#(
	parameter int TICK_CYC = 10
)
(
	// clock, reset, bus
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// machine outputs
	input wire logic weld_enable,
	input wire logic warning_lamp,
	input wire logic fault_lamp_red,
	input wire logic fault_lamp_green,
	input wire logic [3:0] error_code
);
	localparam logic [15:0] RED = 16'h0226;
	localparam logic [15:0] GRN = 16'h01aa;
	localparam int CPU_LIM = 1001 * TICK_CYC + 10;
	int cpu_cnt;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// cycles of welding still allowed under a processor fault
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cpu_cnt <= 0;
		else if (error_code == 4'h9 && weld_enable)
			cpu_cnt <= cpu_cnt + 1;
		else
			cpu_cnt <= 0;
	end
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_steady;
		error_code inside {4'h1, 4'h3, 4'h4, 4'h8} ##1 $stable(error_code);
	endsequence
	a_pready_one_wait: assert property (s_setup |=> pready ##1 !pready)
		else $error("pready not one access cycle");
	a_unmapped_err: assert property (psel && !penable && paddr > 8'h14 |=> pslverr && !prdata)
		else $error("unmapped access not refused");
	a_fault_stops_weld: assert property (
		$stable(error_code) && error_code inside {[4'h1:4'h8]} |-> !weld_enable)
		else $error("weld on during fault");
	a_latch_holds: assert property (
		error_code inside {4'h1, 4'h3, 4'h4, 4'h8, 4'h9} |=> error_code != 4'h0)
		else $error("latched fault cleared");
	a_steady_lamp: assert property (s_steady |-> warning_lamp)
		else $error("steady lamp off");
	a_red_lut: assert property (
		$stable(error_code)[*2] |-> fault_lamp_red == RED[error_code])
		else $error("red lamp wrong");
	a_green_lut: assert property (
		$stable(error_code)[*2] |-> fault_lamp_green == GRN[error_code])
		else $error("green lamp wrong");
	a_cpu_stop: assert property (cpu_cnt <= CPU_LIM)
		else $error("weld not stopped after cpu fault");
endmodule

bind wfs_supervisor wfs_sva #(.TICK_CYC(TICK_CYC)) u_wfs_sva
(
	.pclk, .presetn, .psel, .penable, .paddr, .prdata, .pready, .pslverr,
	.weld_enable, .warning_lamp, .fault_lamp_red, .fault_lamp_green, .error_code
);

/* verif/wfs_supervisor_tb.sv */
// self-checking bench for the welder fault supervisor
// assumes the machine model and the bound checker
`timescale 1ns/1ps
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin failures++; \
	$display("BAD %s exp %0h got %0h", n, e, a); end end
module wfs_supervisor_tb;
	import wfs_pkg::*;
	localparam logic [15:0] RED = 16'h0226;
	localparam logic [15:0] GRN = 16'h01aa;
	localparam logic [15:0] STD = 16'h011a;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic pready, pslverr, weld_enable, warning_lamp, fault_lamp_red, fault_lamp_green, irq;
	logic [3:0] error_code, sel, mode = 4'h1;
	logic [8:0] cv = 0, pins;
	int failures = 0, check_count = 0, seed = 32'h0554_c2a5, act;
	int sc[3] = '{1, 2, 6}, scc[3] = '{2, 2, 7};
	int lb[6] = '{0, 5, 3, 4, 7, 8}, lc[6] = '{1, 6, 3, 4, 8, 9};
	always #5 pclk = ~pclk;
	wfs_machine_model u_wfs_machine_model (.pclk, .cv, .mode, .pins, .sel);
	wfs_supervisor #(.TICK_CYC(10), .OVC_MS(5), .GAS_MS(8)) u_wfs_supervisor
	(
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.freq_unstable(pins[0]), .temp_over(pins[1]), .duty_over(pins[2]),
		.volt_high(pins[3]), .volt_low(pins[4]), .process_mode_selector(sel),
		.torch_trigger(pins[5]), .gas_check(pins[6]), .overcurrent(pins[7]),
		.cpu_fault(pins[8]), .weld_enable, .warning_lamp, .fault_lamp_red,
		.fault_lamp_green, .error_code, .irq
	);
	// ****
	// tasks
	// ****
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1)
		begin
			failures++;
			report_and_stop();
		end
		@(posedge pclk);
	endtask
	task automatic wait_code(input logic [3:0] c, input int lim);
		int n;
		n = 0;
		while (error_code !== c && n < lim)
		begin
			@(posedge pclk);
			n++;
		end
		if (n >= lim)
		begin
			failures++;
			report_and_stop();
		end
	endtask
	function automatic logic [3:0] lowest(input int m);
		for (int i = 0; i < 9; i++)
			if (m[i])
				return 4'(i + 1);
		return 4'h0;
	endfunction
	task automatic check_out(input logic [3:0] c);
		repeat (3) @(posedge pclk);
		`CHK("code", c, error_code)
		`CHK("red", RED[c], fault_lamp_red)
		`CHK("green", GRN[c], fault_lamp_green)
		if (c != 4'h9)
			`CHK("weld", c == 4'h0, weld_enable)
		if (STD[c])
			`CHK("steady", 1'b1, warning_lamp)
	endtask
	// lamp on-time over one blink period
	task automatic duty(input int e);
		int n;
		n = 0;
		repeat (10000)
		begin
			@(posedge pclk);
			n += (warning_lamp === 1'b1);
		end
		`CHK("lamp on", e, n)
	endtask
	task automatic power_up(input logic [8:0] v);
		cv <= v;
		presetn <= 1'b0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b1, REG_CTRL, 32'h1);
	endtask
	// ****
	// sequence
	// ****
	initial
	begin
		@(posedge pclk);
		power_up(9'h000);
		apb(1'b0, REG_MODEOK, 32'h0);
		`CHK("modeok", 32'h0000_00ff, rd)
		apb(1'b0, REG_MASK, 32'h0);
		`CHK("mask", 32'h0, rd)
		apb(1'b0, 8'h18, 32'h0);
		`CHK("slverr", 1'b1, err)
		`CHK("unmapped", 32'h0, rd)
		apb(1'b1, REG_MASK, 32'h1ff);
		repeat (300) @(posedge pclk);
		check_out(4'h0);
		$display("test registers done");
		foreach (sc[i])
		begin
			cv <= 9'h1 << sc[i];
			wait_code(4'(scc[i]), 400);
			check_out(4'(scc[i]));
			`CHK("irq", 1'b1, irq)
			apb(1'b0, REG_STATUS, 32'h0);
			`CHK("status", 32'h1 << (scc[i] - 1), rd)
			cv <= 9'h0;
			wait_code(4'h0, 50);
			check_out(4'h0);
			apb(1'b1, REG_STATUS, 32'h1 << (scc[i] - 1));
			apb(1'b0, REG_STATUS, 32'h0);
			`CHK("status", 32'h0, rd)
			`CHK("irq", 1'b0, irq)
		end
		$display("test self clearing done");
		apb(1'b1, REG_MASK, 32'h0);
		mode <= 4'h8 + 4'($random(seed) & 7);
		wait_code(4'h5, 50);
		check_out(4'h5);
		cv <= 9'h002;
		wait_code(4'h2, 50);
		check_out(4'h2);
		`CHK("masked irq", 1'b0, irq)
		apb(1'b0, REG_ERR, 32'h0);
		`CHK("err reg", 32'h2, rd)
		apb(1'b0, REG_LIVE, 32'h0);
		`CHK("live", 32'h12, rd)
		duty(5000);
		cv <= 9'h0;
		apb(1'b1, REG_MODEOK, 32'h0000_ffff);
		wait_code(4'h0, 50);
		check_out(4'h0);
		apb(1'b1, REG_MODEOK, {16'h0000, MODEOK_RST});
		wait_code(4'h5, 50);
		check_out(4'h5);
		mode <= 4'h1;
		wait_code(4'h0, 50);
		check_out(4'h0);
		// overcurrent burst shorter than the 5 ms limit of this bench
		cv <= 9'h080;
		repeat (30) @(posedge pclk);
		cv <= 9'h0;
		check_out(4'h0);
		$display("test mode and priority done");
		foreach (lb[i])
		begin
			power_up(9'h1 << lb[i]);
			act = 1 << (lc[i] - 1);
			wait_code(4'(lc[i]), 400);
			check_out(4'(lc[i]));
			cv <= 9'h0;
			if (lc[i] == 6)
				act = 0;
			if (lc[i] == 9)
			begin
				duty(3000);
				`CHK("cpu weld", 1'b0, weld_enable)
			end
			repeat (100) @(posedge pclk);
			check_out(lowest(act));
		end
		$display("test latched done");
		report_and_stop();
	end
endmodule
